// [logic/dcsma_pkg.sv]
// Purpose: shared constants and types of the dual core shared memory arbiter
// Assumes: one system clock, 24-bit core address and data
// Notes:   address decode values derive from the shared region base and size
`default_nettype none
package dcsma_pkg;
   localparam int          DCSMA_ADDR_W     = 24;
   localparam int          DCSMA_DATA_W     = 24;
   localparam int          DCSMA_NUM_BLK    = 8;
   localparam int          DCSMA_BLK_WORDS  = 4096;
   localparam int          DCSMA_BLK_IDX_W  = 3;
   localparam int          DCSMA_WORD_IDX_W = 12;
   localparam int          DCSMA_TOTAL_WORDS = DCSMA_NUM_BLK * DCSMA_BLK_WORDS;
   localparam int          DCSMA_REGION_LSB = DCSMA_BLK_IDX_W + DCSMA_WORD_IDX_W;
   localparam logic [23:0] DCSMA_BASE_ADDR  = 24'h03_0000;
   localparam logic [DCSMA_ADDR_W-DCSMA_REGION_LSB-1:0] DCSMA_BASE_HI =
      DCSMA_BASE_ADDR[DCSMA_ADDR_W-1:DCSMA_REGION_LSB];
   localparam logic        DCSMA_RR_LAST_RST = 1'b1;
   localparam logic [23:0] DCSMA_RDATA_RST  = 24'h00_0000;

   // config field encoding: round robin, core 0 first, core 1 first
   typedef enum logic [1:0] {
      DCSMA_POL_RR,
      DCSMA_POL_CORE0,
      DCSMA_POL_CORE1
   } dcsma_policy_t;

   typedef struct packed {
      logic                    req;
      logic                    we;
      logic [DCSMA_ADDR_W-1:0] addr;
      logic [DCSMA_DATA_W-1:0] wdata;
   } dcsma_req_t;

   typedef struct packed {
      logic                    ack;
      logic                    err;
      logic [DCSMA_DATA_W-1:0] rdata;
   } dcsma_rsp_t;

   typedef struct packed {
      logic last_b;
   } dcsma_arb_st_t;

   typedef struct packed {
      dcsma_rsp_t rsp0;
      dcsma_rsp_t rsp1;
   } dcsma_top_st_t;
endpackage
`default_nettype wire

// [logic/dcsma_blk_arb.sv]
// Purpose: two way arbiter for one single port memory block
// Assumes: requests are levels held until granted
// Notes:   grants are combinational, only the round robin turn is stored
`timescale 1ns/1ps
`default_nettype none
module dcsma_blk_arb (
   input  wire logic                    clk_sys_i,
   input  wire logic                    nrst_i,
   input  wire logic                    req_a_i,
   input  wire logic                    req_b_i,
   input  wire dcsma_pkg::dcsma_policy_t policy_i,
   output logic                         gnt_a_o,
   output logic                         gnt_b_o
);
   import dcsma_pkg::*;

   dcsma_arb_st_t st;
   dcsma_arb_st_t next_st;
   logic          contend;

   assign contend = req_a_i && req_b_i;

   always_comb begin
      next_st = st;
      gnt_a_o = req_a_i && !req_b_i; // RL6
      gnt_b_o = req_b_i && !req_a_i; // RL6
      if (contend) begin
         case (policy_i)
            DCSMA_POL_CORE0: begin
               gnt_a_o = 1'b1; // RL9
            end
            DCSMA_POL_CORE1: begin
               gnt_b_o = 1'b1; // RL10
            end
            DCSMA_POL_RR: begin
               // turn flips only on contention so a solo user never steals it
               gnt_a_o        = st.last_b; // RL11
               gnt_b_o        = !st.last_b; // RL11
               next_st.last_b = !st.last_b; // RL11
            end
            default: begin
               gnt_a_o = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st.last_b <= DCSMA_RR_LAST_RST;
      end else begin
         st <= next_st;
      end
   end

   a_one_grant: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL4
      !(gnt_a_o && gnt_b_o)) else $error("both requesters granted");
   a_solo_wins: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL6
      (req_a_i != req_b_i) |-> (gnt_a_o == req_a_i) && (gnt_b_o == req_b_i))
      else $error("lone request not granted");
   a_core0_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL9
      contend && policy_i == DCSMA_POL_CORE0 |-> gnt_a_o)
      else $error("core 0 lost in core 0 priority mode");
   a_core1_first: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL10
      contend && policy_i == DCSMA_POL_CORE1 |-> gnt_b_o)
      else $error("core 1 lost in core 1 priority mode");
   a_rr_alternate: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL11
      contend && policy_i == DCSMA_POL_RR && gnt_a_o
      ##1 (contend && policy_i == DCSMA_POL_RR)[*1] |-> gnt_b_o)
      else $error("round robin did not alternate");
   c_rr_contend: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      contend && policy_i == DCSMA_POL_RR ##1 contend && policy_i == DCSMA_POL_RR);
endmodule
`default_nettype wire

// [logic/dcsma_top.sv]
// Purpose: shared memory of eight single port blocks reached by two cores
// Assumes: each core muxes its cpu and dma traffic onto its own request port
// Notes:   one access per block per cycle, answers are registered
`timescale 1ns/1ps
`default_nettype none
// How it works
// [RL1] the shared store is eight independent single port blocks of 4K 24-bit words.
// [RL2] the blocks together hold 32K words decoded from base address 0x030000.
// [RL3] the region answers the same way whether the core used X, Y or program space.
// [RL4] every block has its own arbiter that picks one core when both address it.
// [RL5] cores addressing different blocks are both served in the same cycle.
// [RL6] a core sees no delay unless the other requester wants the same block.
// [RL7] the losing core is held off until its block is free and then served.
// [RL8] a configuration field chooses round robin, core 0 first or core 1 first.
// [RL9] in core 0 priority mode core 0 always wins a contended block.
// [RL10] in core 1 priority mode core 1 always wins a contended block.
// [RL11] in round robin mode contended grants of a block alternate between cores.
// [RL12] a stalled core keeps address, data and control stable until granted.
module dcsma_top (
   input  wire logic                     clk_sys_i,
   input  wire logic                     nrst_i,
   input  wire dcsma_pkg::dcsma_policy_t policy_i,
   input  wire dcsma_pkg::dcsma_req_t    req0_i,
   input  wire dcsma_pkg::dcsma_req_t    req1_i,
   output dcsma_pkg::dcsma_rsp_t         rsp0_o,
   output dcsma_pkg::dcsma_rsp_t         rsp1_o
);
   import dcsma_pkg::*;

   dcsma_top_st_t st;
   dcsma_top_st_t next_st;

   logic [DCSMA_DATA_W-1:0]     mem [0:DCSMA_NUM_BLK-1][0:DCSMA_BLK_WORDS-1];

   logic                        in_rng0;
   logic                        in_rng1;
   logic [DCSMA_BLK_IDX_W-1:0]  blk0;
   logic [DCSMA_BLK_IDX_W-1:0]  blk1;
   logic [DCSMA_WORD_IDX_W-1:0] word0;
   logic [DCSMA_WORD_IDX_W-1:0] word1;
   logic [DCSMA_NUM_BLK-1:0]    hit0;
   logic [DCSMA_NUM_BLK-1:0]    hit1;
   logic [DCSMA_NUM_BLK-1:0]    gnt0;
   logic [DCSMA_NUM_BLK-1:0]    gnt1;
   logic                        take0;
   logic                        take1;
   logic                        oor0;
   logic                        oor1;

   // the space selector is not decoded: X, Y and P all land on one store
   assign in_rng0 = req0_i.addr[DCSMA_ADDR_W-1:DCSMA_REGION_LSB] == DCSMA_BASE_HI; // RL2 RL3
   assign in_rng1 = req1_i.addr[DCSMA_ADDR_W-1:DCSMA_REGION_LSB] == DCSMA_BASE_HI; // RL2 RL3
   assign blk0    = req0_i.addr[DCSMA_REGION_LSB-1:DCSMA_WORD_IDX_W];
   assign blk1    = req1_i.addr[DCSMA_REGION_LSB-1:DCSMA_WORD_IDX_W];
   assign word0   = req0_i.addr[DCSMA_WORD_IDX_W-1:0];
   assign word1   = req1_i.addr[DCSMA_WORD_IDX_W-1:0];
   assign oor0    = req0_i.req && !in_rng0;
   assign oor1    = req1_i.req && !in_rng1;

   genvar gb;
   generate
      for (gb = 0; gb < DCSMA_NUM_BLK; gb++) begin : g_blk
         assign hit0[gb] = req0_i.req && in_rng0 && (blk0 == DCSMA_BLK_IDX_W'(gb));
         assign hit1[gb] = req1_i.req && in_rng1 && (blk1 == DCSMA_BLK_IDX_W'(gb));
         // one arbiter per block keeps different blocks fully parallel
         dcsma_blk_arb u_arb ( // RL4 RL5
            .clk_sys_i (clk_sys_i),
            .nrst_i    (nrst_i),
            .req_a_i   (hit0[gb]),
            .req_b_i   (hit1[gb]),
            .policy_i  (policy_i), // RL8
            .gnt_a_o   (gnt0[gb]),
            .gnt_b_o   (gnt1[gb])
         );
      end
   endgenerate

   // an in-range request without a grant simply gets no ack and waits
   assign take0 = |gnt0; // RL7
   assign take1 = |gnt1; // RL7

   always_comb begin
      next_st            = st;
      next_st.rsp0.ack   = take0 || oor0;
      next_st.rsp0.err   = oor0;
      next_st.rsp0.rdata = DCSMA_RDATA_RST;
      if (take0 && !req0_i.we) begin
         next_st.rsp0.rdata = mem[blk0][word0];
      end
      next_st.rsp1.ack   = take1 || oor1;
      next_st.rsp1.err   = oor1;
      next_st.rsp1.rdata = DCSMA_RDATA_RST;
      if (take1 && !req1_i.we) begin
         next_st.rsp1.rdata = mem[blk1][word1];
      end
   end

   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         st.rsp0.ack   <= 1'b0;
         st.rsp0.err   <= 1'b0;
         st.rsp0.rdata <= DCSMA_RDATA_RST;
         st.rsp1.ack   <= 1'b0;
         st.rsp1.err   <= 1'b0;
         st.rsp1.rdata <= DCSMA_RDATA_RST;
      end else begin
         st <= next_st;
      end
   end

   // arbiters never grant one block twice, so the two writes never collide
   always_ff @(posedge clk_sys_i) begin
      if (take0 && req0_i.we) begin
         mem[blk0][word0] <= req0_i.wdata; // RL1 RL12
      end
      if (take1 && req1_i.we) begin
         mem[blk1][word1] <= req1_i.wdata; // RL1 RL12
      end
   end

   assign rsp0_o = st.rsp0;
   assign rsp1_o = st.rsp1;

   // helper model of one word for a read after write check on core 0
   logic [DCSMA_ADDR_W-1:0] chk_addr;
   logic [DCSMA_DATA_W-1:0] chk_data;
   logic                    chk_vld;
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         chk_addr <= DCSMA_BASE_ADDR;
         chk_data <= DCSMA_RDATA_RST;
         chk_vld  <= 1'b0;
      end else if (take0 && req0_i.we) begin
         chk_addr <= req0_i.addr;
         chk_data <= req0_i.wdata;
         chk_vld  <= 1'b1;
      end else if (take1 && req1_i.we && req1_i.addr == chk_addr) begin
         chk_vld  <= 1'b0;
      end
   end

   a_word_kept: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL1
      chk_vld && take0 && !req0_i.we && req0_i.addr == chk_addr
      && !(take1 && req1_i.we && req1_i.addr == chk_addr)
      |=> rsp0_o.ack && rsp0_o.rdata == $past(chk_data))
      else $error("shared word read back wrong");
   a_range_err: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL2
      req0_i.req && req0_i.addr[DCSMA_ADDR_W-1:DCSMA_REGION_LSB] != DCSMA_BASE_HI
      |=> rsp0_o.ack && rsp0_o.err)
      else $error("outside access not flagged");
   a_range_ok: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL2
      rsp1_o.ack && !rsp1_o.err |->
      $past(req1_i.addr) >= DCSMA_BASE_ADDR
      && $past(req1_i.addr) < DCSMA_BASE_ADDR + DCSMA_TOTAL_WORDS)
      else $error("ack outside shared region");
   a_parallel_blocks: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL5
      req0_i.req && req1_i.req && in_rng0 && in_rng1 && blk0 != blk1
      |=> rsp0_o.ack && rsp1_o.ack && !rsp0_o.err && !rsp1_o.err)
      else $error("different blocks not served together");
   a_clash_one_wins: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL7
      req0_i.req && req1_i.req && in_rng0 && in_rng1 && blk0 == blk1
      |=> rsp0_o.ack != rsp1_o.ack)
      else $error("clash did not serve exactly one core");
   a_loser_served: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL7
      policy_i == DCSMA_POL_RR && req1_i.req && in_rng1 && !take1
      ##1 (req1_i.req && $stable(req1_i.addr) && policy_i == DCSMA_POL_RR)
      |=> rsp1_o.ack)
      else $error("stalled core not served in round robin");
   a_ack_has_cause: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL6
      rsp0_o.ack |-> $past(req0_i.req))
      else $error("ack without a request");
   a_pri0_serves: assert property (@(posedge clk_sys_i) disable iff (!nrst_i) // RL9
      policy_i == DCSMA_POL_CORE0 && req0_i.req && in_rng0 |=> rsp0_o.ack)
      else $error("core 0 delayed in core 0 priority mode");

   c_clash: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      req0_i.req && req1_i.req && in_rng0 && in_rng1 && blk0 == blk1);
   c_parallel: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      take0 && take1);
   c_stall_then_ack: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      req1_i.req && in_rng1 && !take1 ##1 take1 ##1 rsp1_o.ack);
   c_out_of_range: cover property (@(posedge clk_sys_i) disable iff (!nrst_i)
      rsp0_o.err);
endmodule
`default_nettype wire

// [sim/dcsma_core_mdl.sv]
// Purpose: model of one core with its dma muxed onto one request port
// Assumes: the bench queues commands with push
// Notes:   idle address and data toggle so stale values never pass
`timescale 1ns/1ps
`default_nettype none
module dcsma_core_mdl (
   input  wire logic                  clk_sys_i,
   input  wire logic                  nrst_i,
   input  wire dcsma_pkg::dcsma_rsp_t rsp_i,
   output var  dcsma_pkg::dcsma_req_t req_o
);
   import dcsma_pkg::*;
   dcsma_req_t cmd_q[$];
   initial req_o = '0;
   task automatic push(input dcsma_req_t c);
      cmd_q.push_back(c);
   endtask
   always @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         req_o = '0;
      end else begin
         #1;
         // a stalled request stays frozen until its ack shows
         if (!req_o.req || rsp_i.ack) begin
            if (cmd_q.size() > 0) begin
               req_o = cmd_q.pop_front();
            end else begin
               req_o.req   = 1'b0;
               req_o.addr  = ~req_o.addr;
               req_o.wdata = ~req_o.wdata;
            end
         end
      end
   end
endmodule
`default_nettype wire

// [sim/dcsma_top_tb.sv]
// Purpose: self-checking bench of the shared memory arbiter
// Assumes: ack comes two cycles after a free request is queued
// Notes:   expectations carry the cycle in which ack must show
`timescale 1ns/1ps
`default_nettype none
module dcsma_top_tb;
   import dcsma_pkg::*;
   typedef struct {dcsma_rsp_t rsp; int cyc;} dcsma_exp_t;
   logic          clk_sys;
   logic          nrst;
   dcsma_policy_t policy;
   dcsma_req_t    req0;
   dcsma_req_t    req1;
   dcsma_rsp_t    rsp0;
   dcsma_rsp_t    rsp1;
   dcsma_exp_t    exp_q[2][$];
   logic [23:0]   mem[0:32767];
   logic [23:0]   adr[0:15];
   logic [11:0]   wd;
   integer        seed;
   int            cyc;
   int            n_mismatch;
   int            total_checks;
   dcsma_top i_dut (.clk_sys_i(clk_sys), .nrst_i(nrst), .policy_i(policy),
                    .req0_i(req0), .req1_i(req1), .rsp0_o(rsp0), .rsp1_o(rsp1));
   dcsma_core_mdl i_core0 (.clk_sys_i(clk_sys), .nrst_i(nrst), .rsp_i(rsp0), .req_o(req0));
   dcsma_core_mdl i_core1 (.clk_sys_i(clk_sys), .nrst_i(nrst), .rsp_i(rsp1), .req_o(req1));
   initial clk_sys = 1'b0;
   always #25 clk_sys = ~clk_sys;
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   task automatic issue(input int core, input logic we, input logic [23:0] a,
                        input logic [23:0] d, input int dly);
      dcsma_req_t c;
      dcsma_exp_t e;
      logic       in_rng;
      c = '{req: 1'b1, we: we, addr: a, wdata: d};
      in_rng = (a >= 24'h03_0000) && (a < 24'h03_8000);
      e.cyc = cyc + dly;
      e.rsp.ack = 1'b1;
      e.rsp.err = !in_rng;
      e.rsp.rdata = (in_rng && !we) ? mem[a[14:0]] : 24'h00_0000;
      if (in_rng && we) mem[a[14:0]] = d;
      exp_q[core].push_back(e);
      if (core == 1) i_core1.push(c);
      else i_core0.push(c);
   endtask
   task automatic cmp_rsp(input int core, input dcsma_rsp_t r);
      dcsma_exp_t e;
      total_checks++;
      if (exp_q[core].size() == 0) begin
         n_mismatch++;
         $display("ERROR %0t core %0d ack not expected", $time, core);
      end else begin
         e = exp_q[core].pop_front();
         if (r !== e.rsp || cyc != e.cyc) begin
            n_mismatch++;
            $display("ERROR %0t core %0d answer or timing wrong", $time, core);
         end
      end
   endtask
   always @(negedge clk_sys) begin
      cyc = cyc + 1;
      if (rsp0.ack === 1'b1) cmp_rsp(0, rsp0);
      if (rsp1.ack === 1'b1) cmp_rsp(1, rsp1);
   end
   task automatic drain();
      int n;
      n = 0;
      while ((exp_q[0].size() + exp_q[1].size()) > 0 && n < 30) begin
         @(posedge clk_sys);
         n++;
      end
      if (n >= 30) begin
         n_mismatch++;
         $display("ERROR %0t acks missing", $time);
      end
      @(posedge clk_sys);
   endtask
   // same block, winner answered first, loser one cycle later
   task automatic clash(input int blk, input int win);
      issue(0, 1'b0, adr[blk], 24'h00_0000, (win == 1) ? 3 : 2);
      issue(1, 1'b0, adr[8 + (blk + 4) % 8], 24'h00_0000, (win == 1) ? 2 : 3);
      drain();
   endtask
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      summarize();
   end
   initial begin
      seed = 32'h0e17;
      cyc = 0;
      n_mismatch = 0;
      total_checks = 0;
      nrst = 1'b0;
      policy = DCSMA_POL_RR;
      repeat (4) @(posedge clk_sys);
      nrst <= 1'b1;
      @(posedge clk_sys);
      for (int b = 0; b < 16; b++) begin
         wd = (b == 0) ? 12'h000 : (b == 7) ? 12'hFFF : 12'($random(seed));
         adr[b] = 24'h03_0000 | {9'h000, 3'((b + ((b > 7) ? 4 : 0)) % 8), wd};
      end
      // both cores on different blocks every cycle, back to back
      for (int b = 0; b < 8; b++) begin
         issue(0, 1'b1, adr[b], 24'($random(seed)), 2 + b);
         issue(1, 1'b1, adr[8 + b], 24'($random(seed)), 2 + b);
      end
      drain();
      for (int b = 0; b < 8; b++) begin
         issue(0, 1'b0, adr[8 + b], 24'h00_0000, 2 + b);
         issue(1, 1'b0, adr[b], 24'h00_0000, 2 + b);
      end
      drain();
      clash(3, 0);
      clash(3, 1);
      clash(3, 0);
      clash(5, 0);
      // two contended reads per core: grants of block 1 take turns
      issue(0, 1'b0, adr[1], 24'h00_0000, 2);
      issue(0, 1'b0, adr[1], 24'h00_0000, 4);
      issue(1, 1'b0, adr[13], 24'h00_0000, 3);
      issue(1, 1'b0, adr[13], 24'h00_0000, 5);
      drain();
      policy <= DCSMA_POL_CORE0;
      @(posedge clk_sys);
      clash(2, 0);
      clash(2, 0);
      policy <= DCSMA_POL_CORE1;
      @(posedge clk_sys);
      clash(2, 1);
      clash(2, 1);
      clash(6, 1);
      // core 0 reads back its own last write after losing the block
      clash(7, 1);
      // unused policy code behaves as core 0 first
      policy <= dcsma_policy_t'(2'h3);
      @(posedge clk_sys);
      clash(4, 0);
      issue(0, 1'b1, 24'h02_FFFF, 24'($random(seed)), 2);
      issue(1, 1'b0, 24'h03_8000, 24'h00_0000, 2);
      drain();
      summarize();
   end
endmodule
`default_nettype wire
